// >>> hw/drive_seq_cfg.svh
// Register map, reset values, write masks and timing figures of the start/stop sequencer.
`ifndef DRIVE_SEQ_CFG_SVH
`define DRIVE_SEQ_CFG_SVH

`define CLK_HZ          25000000
`define TICK_MS         100

`define OFS_CTRL        8'h00
`define OFS_FREQ        8'h04
`define OFS_BRAKE       8'h08
`define OFS_TRACK       8'h0C
`define OFS_SETF        8'h10
`define OFS_STATUS      8'h14

`define RST_CTRL        32'h00000003
`define RST_FREQ        32'h00050005
`define RST_BRAKE       32'h00140000
`define RST_TRACK       32'h00059632
`define RST_SETF        32'h000001F4

`define MASK_CTRL       32'h0000003F
`define MASK_FREQ       32'h01FF01FF
`define MASK_BRAKE      32'h00FFFFFF
`define MASK_TRACK      32'h00FFFFFF
`define MASK_SETF       32'h00003FFF

`define SRC_PANEL       2'h0
`define SRC_TERM        2'h1
`define SRC_COMM        2'h2

`define RAMP_STEP       14'h000A
`define TRACK_STEP      14'h0014
`define VOLT_FULL       11'h3E8

`define PIN_RUN_KEY     0
`define PIN_STOP_KEY    1
`define PIN_PANEL_REV   2
`define PIN_TERM_RUN    3
`define PIN_TERM_REV    4
`define PIN_COUNT       5

`endif

// >>> hw/drive_seq_pkg.sv
// Types shared by the start/stop sequencer.
package drive_seq_pkg;

	typedef enum logic [2:0] {
		ST_IDLE        = 3'h0,
		ST_START_BRAKE = 3'h1,
		ST_TRACK       = 3'h2,
		ST_ACCEL       = 3'h3,
		ST_RUN         = 3'h4,
		ST_DECEL       = 3'h5,
		ST_STOP_BRAKE  = 3'h6
	} seq_state_t;

	typedef struct packed {
		logic        reverse_enable_setting;
		logic        panel_stop_key_enable;
		logic        startup_mode_select;
		logic        stop_mode_select;
		logic [1:0]  command_source_select;
		logic [8:0]  startup_frequency;
		logic [8:0]  stop_frequency;
		logic [7:0]  start_brake_duration;
		logic [7:0]  stop_brake_duration;
		logic [7:0]  brake_level_percent;
		logic [7:0]  tracking_time;
		logic [7:0]  tracking_current_limit;
		logic [7:0]  tracking_voltage_rise_time;
		logic [13:0] set_frequency;
	} seq_cfg_t;

	typedef struct packed {
		logic run;
		logic rev;
	} run_cmd_t;

endpackage : drive_seq_pkg

// >>> hw/drive_start_stop_sequencer.sv
// Start/stop sequencer of a motor drive with an APB register file.
//
// Summary of operation
// - Reverse enable bit, factory default permits reverse.
// - Reverse forbidden forces forward direction always.
// - Panel stop key honoured for terminal/communication sources.
// - After panel stop, run must drop and return.
// - Mode 0, no brake: start at startup frequency.
// - Mode 0 with brake time: DC brake first.
// - Mode 1: track down from set frequency.
// - Stop mode 0, no brake: decelerate, then coast.
// - Stop mode 0 with brake: decelerate, then brake.
// - Stop mode 1: cut output at once, never brake.
// - Startup frequency 0.1 to 30.0 Hz, default 0.5.
// - Reaching stop frequency ends the deceleration.
// - Start brake 0 to 25 s, mode 0 only.
// - Stop brake 0 to 25 s, stop mode 0 only.
// - Brake level 0 to 20 percent of full voltage; volt_out takes it unscaled, in tenths of a percent.
// - After tracking, accelerate from caught frequency.
// - Overcurrent during tracking lowers the frequency.
// - Tracking voltage ramps up over rise time.
`timescale 1ns/10ps
`include "drive_seq_cfg.svh"

module drive_start_stop_sequencer #(
	parameter int unsigned TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Panel keys and terminal inputs, asynchronous pins.
	input  wire logic        panel_run_key,
	input  wire logic        panel_stop_key,
	input  wire logic        panel_rev_select,
	input  wire logic        term_run,
	input  wire logic        term_rev,
	// Communication commands and current feedback, same clock.
	input  wire logic        comm_run,
	input  wire logic        comm_rev,
	input  wire logic [7:0]  output_current_pct,
	// Setpoints to the power stage.
	output logic      [13:0] freq_out,
	output logic      [10:0] volt_out,
	output logic             output_enable,
	output logic             dc_brake_active,
	output logic             reverse_out
);

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction : merge_strb

	function automatic logic [13:0] step_toward(input logic [13:0] cur, input logic [13:0] tgt,
		input logic [13:0] step);
		logic [13:0] res;
		res = cur;
		if (cur < tgt) begin
			res = (tgt - cur < step) ? tgt : cur + step;
		end else if (cur > tgt) begin
			res = (cur - tgt < step) ? tgt : cur - step;
		end
		return res;
	endfunction : step_toward

	function automatic logic ticks_done(input logic [7:0] elapsed, input logic [7:0] dur);
		return {1'b0, elapsed} + 9'h001 >= {1'b0, dur};
	endfunction : ticks_done

	// APB register file.
	logic [31:0] ctrl_reg;
	logic [31:0] freq_cfg_reg;
	logic [31:0] brake_cfg_reg;
	logic [31:0] track_cfg_reg;
	logic [31:0] setf_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] status_word;
	logic        apb_access;
	logic        apb_write;
	logic        addr_hit;
	drive_seq_pkg::seq_cfg_t cfg;

	assign apb_access = psel & penable & ~pready_reg;
	assign apb_write  = psel & penable & pready_reg & pwrite;
	assign addr_hit   = paddr == `OFS_CTRL || paddr == `OFS_FREQ || paddr == `OFS_BRAKE ||
		paddr == `OFS_TRACK || paddr == `OFS_SETF || paddr == `OFS_STATUS;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_reg      <= `RST_CTRL;
			freq_cfg_reg  <= `RST_FREQ;
			brake_cfg_reg <= `RST_BRAKE;
			track_cfg_reg <= `RST_TRACK;
			setf_reg      <= `RST_SETF;
		end else if (apb_write) begin
			case (paddr)
				`OFS_CTRL:  ctrl_reg      <= merge_strb(ctrl_reg, pwdata, pstrb, `MASK_CTRL);
				`OFS_FREQ:  freq_cfg_reg  <= merge_strb(freq_cfg_reg, pwdata, pstrb, `MASK_FREQ);
				`OFS_BRAKE: brake_cfg_reg <= merge_strb(brake_cfg_reg, pwdata, pstrb, `MASK_BRAKE);
				`OFS_TRACK: track_cfg_reg <= merge_strb(track_cfg_reg, pwdata, pstrb, `MASK_TRACK);
				`OFS_SETF:  setf_reg      <= merge_strb(setf_reg, pwdata, pstrb, `MASK_SETF);
				default: begin
				end
			endcase
		end
	end

	// The answer comes one cycle into the access phase, with data and error registered.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= apb_access;
			if (apb_access) begin
				pslverr_reg <= ~addr_hit;
				case (paddr)
					`OFS_CTRL:   prdata_reg <= ctrl_reg;
					`OFS_FREQ:   prdata_reg <= freq_cfg_reg;
					`OFS_BRAKE:  prdata_reg <= brake_cfg_reg;
					`OFS_TRACK:  prdata_reg <= track_cfg_reg;
					`OFS_SETF:   prdata_reg <= setf_reg;
					`OFS_STATUS: prdata_reg <= status_word;
					default:     prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// The struct lists its fields from the top bit down, so each register is unpacked field by field.
	assign cfg = {ctrl_reg[0], ctrl_reg[1], ctrl_reg[2], ctrl_reg[3], ctrl_reg[5:4], freq_cfg_reg[8:0],
		freq_cfg_reg[24:16], brake_cfg_reg[7:0], brake_cfg_reg[15:8], brake_cfg_reg[23:16], track_cfg_reg[7:0],
		track_cfg_reg[15:8], track_cfg_reg[23:16], setf_reg[13:0]};

	// Tenth-second time base.
	logic [21:0] tick_cnt_reg;
	logic        tick_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst || tick_cnt_reg == 22'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 22'h000000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 22'h000001;
		end
		tick_reg <= !sys_rst && tick_cnt_reg == 22'(TICK_CYCLES - 1);
	end

	// Pin synchronisers and key edges.
	logic [`PIN_COUNT-1:0] pin_meta_reg;
	logic [`PIN_COUNT-1:0] pin_sync_reg;
	logic [`PIN_COUNT-1:0] pin_prev_reg;
	logic                  run_key_press;
	logic                  stop_key_press;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			pin_prev_reg <= '0;
		end else begin
			pin_meta_reg <= {term_rev, term_run, panel_rev_select, panel_stop_key, panel_run_key};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign run_key_press  = pin_sync_reg[`PIN_RUN_KEY] & ~pin_prev_reg[`PIN_RUN_KEY];
	assign stop_key_press = pin_sync_reg[`PIN_STOP_KEY] & ~pin_prev_reg[`PIN_STOP_KEY];

	// Command source selection and the panel stop lockout.
	logic                      panel_latch_reg;
	logic                      lockout_reg;
	logic                      ext_source;
	logic                      ext_run;
	drive_seq_pkg::run_cmd_t   cmd;

	assign ext_source = cfg.command_source_select == `SRC_TERM || cfg.command_source_select == `SRC_COMM;
	assign ext_run    = (cfg.command_source_select == `SRC_TERM) ? pin_sync_reg[`PIN_TERM_RUN] :
		(cfg.command_source_select == `SRC_COMM) ? comm_run : 1'b0;

	always_ff @(posedge clk_sys) begin
		if (sys_rst || cfg.command_source_select != `SRC_PANEL || stop_key_press) begin
			panel_latch_reg <= 1'b0;
		end else if (run_key_press) begin
			panel_latch_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lockout_reg <= 1'b0;
		end else if (stop_key_press && cfg.panel_stop_key_enable && ext_source && ext_run) begin
			lockout_reg <= 1'b1;
		end else if (!ext_run) begin
			lockout_reg <= 1'b0;
		end
	end

	always_comb begin
		cmd.run = (cfg.command_source_select == `SRC_PANEL) ? panel_latch_reg : ext_run & ~lockout_reg;
		case (cfg.command_source_select)
			`SRC_PANEL: cmd.rev = pin_sync_reg[`PIN_PANEL_REV];
			`SRC_TERM:  cmd.rev = pin_sync_reg[`PIN_TERM_REV];
			`SRC_COMM:  cmd.rev = comm_rev;
			default:    cmd.rev = 1'b0;
		endcase
		cmd.rev = cmd.rev & cfg.reverse_enable_setting;
	end

	// Sequencer state machine.
	drive_seq_pkg::seq_state_t state_reg;
	drive_seq_pkg::seq_state_t state_next;
	drive_seq_pkg::seq_state_t stop_target;
	logic [7:0]  timer_reg;
	logic [13:0] freq_reg;
	logic [10:0] volt_reg;
	logic [13:0] start_freq;
	logic [13:0] target_freq;
	logic [10:0] volt_step;
	logic        over_current;

	assign start_freq   = {5'h00, cfg.startup_frequency};
	assign target_freq  = (cfg.set_frequency < start_freq) ? start_freq : cfg.set_frequency;
	assign over_current = output_current_pct > cfg.tracking_current_limit;
	assign volt_step    = 11'(`VOLT_FULL / ((cfg.tracking_voltage_rise_time == 8'h00) ? 8'h01 :
		cfg.tracking_voltage_rise_time));
	assign stop_target  = cfg.stop_mode_select ? drive_seq_pkg::ST_IDLE : drive_seq_pkg::ST_DECEL;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			drive_seq_pkg::ST_IDLE: begin
				if (cmd.run) begin
					if (cfg.startup_mode_select) begin
						state_next = drive_seq_pkg::ST_TRACK;
					end else if (cfg.start_brake_duration != 8'h00) begin
						state_next = drive_seq_pkg::ST_START_BRAKE;
					end else begin
						state_next = drive_seq_pkg::ST_ACCEL;
					end
				end
			end
			drive_seq_pkg::ST_START_BRAKE: begin
				if (!cmd.run) begin
					state_next = drive_seq_pkg::ST_IDLE;
				end else if (tick_reg && ticks_done(timer_reg, cfg.start_brake_duration)) begin
					state_next = drive_seq_pkg::ST_ACCEL;
				end
			end
			drive_seq_pkg::ST_TRACK: begin
				if (!cmd.run) begin
					state_next = stop_target;
				end else if (tick_reg && ticks_done(timer_reg, cfg.tracking_time)) begin
					state_next = drive_seq_pkg::ST_ACCEL;
				end
			end
			drive_seq_pkg::ST_ACCEL: begin
				if (!cmd.run) begin
					state_next = stop_target;
				end else if (freq_reg == target_freq) begin
					state_next = drive_seq_pkg::ST_RUN;
				end
			end
			drive_seq_pkg::ST_RUN: begin
				if (!cmd.run) begin
					state_next = stop_target;
				end else if (freq_reg != target_freq) begin
					state_next = drive_seq_pkg::ST_ACCEL;
				end
			end
			drive_seq_pkg::ST_DECEL: begin
				if (cmd.run) begin
					state_next = drive_seq_pkg::ST_ACCEL;
				end else if (freq_reg <= {5'h00, cfg.stop_frequency}) begin
					state_next = (cfg.stop_brake_duration != 8'h00) ? drive_seq_pkg::ST_STOP_BRAKE :
						drive_seq_pkg::ST_IDLE;
				end
			end
			drive_seq_pkg::ST_STOP_BRAKE: begin
				if (tick_reg && ticks_done(timer_reg, cfg.stop_brake_duration)) begin
					state_next = drive_seq_pkg::ST_IDLE;
				end
			end
			default: state_next = drive_seq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= drive_seq_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Ticks spent in the current state; restarts on every state change.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state_next != state_reg) begin
			timer_reg <= 8'h00;
		end else if (tick_reg && timer_reg != 8'hFF) begin
			timer_reg <= timer_reg + 8'h01;
		end
	end

	// Frequency and voltage setpoints, voltage in tenths of a percent of full scale.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			freq_reg <= 14'h0000;
			volt_reg <= 11'h000;
		end else begin
			case (state_next)
				drive_seq_pkg::ST_START_BRAKE, drive_seq_pkg::ST_STOP_BRAKE: begin
					freq_reg <= 14'h0000;
					volt_reg <= {3'h0, cfg.brake_level_percent};
				end
				drive_seq_pkg::ST_TRACK: begin
					if (state_reg != drive_seq_pkg::ST_TRACK) begin
						freq_reg <= cfg.set_frequency;
						volt_reg <= 11'h000;
					end else if (tick_reg) begin
						freq_reg <= step_toward(freq_reg, start_freq, over_current ? `TRACK_STEP : `RAMP_STEP);
						volt_reg <= (volt_reg + volt_step >= `VOLT_FULL) ? `VOLT_FULL : volt_reg + volt_step;
					end
				end
				drive_seq_pkg::ST_ACCEL, drive_seq_pkg::ST_RUN: begin
					if (state_reg == drive_seq_pkg::ST_IDLE || state_reg == drive_seq_pkg::ST_START_BRAKE) begin
						freq_reg <= start_freq;
						volt_reg <= `VOLT_FULL;
					end else if (tick_reg) begin
						freq_reg <= step_toward(freq_reg, target_freq, `RAMP_STEP);
						volt_reg <= (volt_reg + volt_step >= `VOLT_FULL) ? `VOLT_FULL : volt_reg + volt_step;
					end
				end
				drive_seq_pkg::ST_DECEL: begin
					if (tick_reg) begin
						freq_reg <= step_toward(freq_reg, {5'h00, cfg.stop_frequency}, `RAMP_STEP);
					end
				end
				default: begin
					freq_reg <= 14'h0000;
					volt_reg <= 11'h000;
				end
			endcase
		end
	end

	// Direction is taken at start and forced forward whenever reverse is forbidden.
	logic dir_reg;
	logic out_en_reg;
	logic brake_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !cfg.reverse_enable_setting) begin
			dir_reg <= 1'b0;
		end else if (state_reg == drive_seq_pkg::ST_IDLE && state_next != drive_seq_pkg::ST_IDLE) begin
			dir_reg <= cmd.rev;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			out_en_reg <= 1'b0;
			brake_reg  <= 1'b0;
		end else begin
			out_en_reg <= state_next != drive_seq_pkg::ST_IDLE;
			brake_reg  <= state_next == drive_seq_pkg::ST_START_BRAKE || state_next == drive_seq_pkg::ST_STOP_BRAKE;
		end
	end

	assign status_word     = {2'h0, freq_reg, 9'h000, brake_reg, lockout_reg, out_en_reg, dir_reg, state_reg};
	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign freq_out        = freq_reg;
	assign volt_out        = volt_reg;
	assign output_enable   = out_en_reg;
	assign dc_brake_active = brake_reg;
	assign reverse_out     = dir_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	AST_REV_FORBID: assert property (!cfg.reverse_enable_setting |=> !dir_reg)
		else $error("Reverse output while reverse is forbidden.");
	AST_LOCKOUT_BLOCKS_RUN: assert property (lockout_reg && ext_source && state_reg == drive_seq_pkg::ST_IDLE
		|=> state_reg == drive_seq_pkg::ST_IDLE)
		else $error("Drive started during panel stop lockout.");
	AST_STOP_KEY_SOURCE: assert property ($rose(lockout_reg) |-> $past(ext_source) && $past(cfg.panel_stop_key_enable))
		else $error("Stop key lockout with wrong source or key disabled.");
	AST_DIRECT_START: assert property (state_reg == drive_seq_pkg::ST_IDLE && cmd.run && !cfg.startup_mode_select
		&& cfg.start_brake_duration == 8'h00 |=> state_reg == drive_seq_pkg::ST_ACCEL && freq_reg == $past(start_freq))
		else $error("Direct start did not begin at startup frequency.");
	AST_BRAKE_FIRST: assert property (state_reg == drive_seq_pkg::ST_IDLE && cmd.run && !cfg.startup_mode_select
		&& cfg.start_brake_duration != 8'h00 |=> state_reg == drive_seq_pkg::ST_START_BRAKE && dc_brake_active)
		else $error("Start braking was skipped.");
	AST_TRACK_ENTRY: assert property (state_reg == drive_seq_pkg::ST_IDLE && cmd.run && cfg.startup_mode_select
		|=> state_reg == drive_seq_pkg::ST_TRACK && freq_reg == $past(cfg.set_frequency) && volt_reg == 11'h000)
		else $error("Tracking start did not begin at set frequency.");
	AST_COAST_STOP: assert property (cfg.stop_mode_select && state_reg == drive_seq_pkg::ST_RUN && !cmd.run
		|=> !output_enable ##1 !dc_brake_active)
		else $error("Coast stop did not cut output.");
	AST_DECEL_END: assert property (state_reg == drive_seq_pkg::ST_DECEL && !cmd.run && cfg.stop_brake_duration == 8'h00
		&& freq_reg <= {5'h00, cfg.stop_frequency} |=> state_reg == drive_seq_pkg::ST_IDLE && !output_enable)
		else $error("Deceleration did not end at stop frequency.");
	AST_STOP_BRAKE: assert property (state_reg == drive_seq_pkg::ST_DECEL && !cmd.run && cfg.stop_brake_duration != 8'h00
		&& freq_reg <= {5'h00, cfg.stop_frequency} |=> dc_brake_active && volt_reg == {3'h0, $past(cfg.brake_level_percent)})
		else $error("Stop braking not applied at stop frequency.");
	AST_TRACK_LOWER: assert property (state_reg == drive_seq_pkg::ST_TRACK && state_next == drive_seq_pkg::ST_TRACK
		&& tick_reg && over_current && freq_reg > start_freq |=> freq_reg < $past(freq_reg))
		else $error("Frequency not lowered on tracking overcurrent.");
	AST_TRACK_VRAMP: assert property (state_reg == drive_seq_pkg::ST_TRACK && state_next == drive_seq_pkg::ST_TRACK
		|=> volt_reg >= $past(volt_reg))
		else $error("Tracking voltage fell during ramp.");
	AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
		else $error("APB answer missing after one wait cycle.");

	COV_TRACK_TO_RUN: cover property (state_reg == drive_seq_pkg::ST_TRACK ##[1:300] state_reg == drive_seq_pkg::ST_RUN);
	COV_STOP_BRAKE_DONE: cover property (state_reg == drive_seq_pkg::ST_STOP_BRAKE ##1 state_reg == drive_seq_pkg::ST_IDLE);
	COV_LOCKOUT: cover property ($rose(lockout_reg));

endmodule : drive_start_stop_sequencer

// >>> testbench/drive_stage_model.sv
// Behavioural power stage and terminal block facing the sequencer.
`timescale 1ns/10ps

module drive_stage_model (
	// Clock.
	input  wire logic        clk_sys,
	// Setpoints from the sequencer.
	input  wire logic [13:0] freq_out,
	input  wire logic        output_enable,
	// Test controls.
	input  wire logic        overload,
	input  wire logic        ext_run,
	input  wire logic        ext_rev,
	// Feedback and terminal pins.
	output logic      [7:0]  output_current_pct,
	output logic             term_run,
	output logic             term_rev
);
	// A loaded motor draws 200 percent while energised, a light one 100 percent.
	always_ff @(posedge clk_sys) begin
		if (output_enable && freq_out != 14'h0000) begin
			output_current_pct <= overload ? 8'hC8 : 8'h64;
		end else begin
			output_current_pct <= 8'h00;
		end
	end

	// Terminal control carries run and direction as plain levels.
	always_ff @(posedge clk_sys) begin
		term_run <= ext_run;
		term_rev <= ext_rev;
	end
endmodule : drive_stage_model

// >>> testbench/tb_drive_start_stop_sequencer.sv
// Self-checking bench of the start/stop sequencer.
`timescale 1ns/10ps
`include "drive_seq_cfg.svh"

module tb_drive_start_stop_sequencer;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        panel_stop_key = 1'b0;
	logic        comm_run = 1'b0;
	logic        comm_rev = 1'b0;
	logic        overload = 1'b0;
	logic        ext_run = 1'b0;
	logic [7:0]  output_current_pct;
	logic        term_run;
	logic        term_rev;
	logic [13:0] freq_out;
	logic [10:0] volt_out;
	logic        output_enable;
	logic        dc_brake_active;
	logic        reverse_out;
	int          brake_cnt = 0;
	int          brake_mark = 0;
	logic [31:0] rdata;
	logic        rerr;
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;

	always #20 clk_sys = ~clk_sys;

	drive_start_stop_sequencer #(.TICK_CYCLES(20)) u_drive_start_stop_sequencer (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .panel_run_key(1'b0), .panel_stop_key(panel_stop_key),
		.panel_rev_select(1'b0), .term_run(term_run), .term_rev(term_rev), .comm_run(comm_run),
		.comm_rev(comm_rev), .output_current_pct(output_current_pct), .freq_out(freq_out),
		.volt_out(volt_out), .output_enable(output_enable), .dc_brake_active(dc_brake_active),
		.reverse_out(reverse_out));

	drive_stage_model u_drive_stage_model (
		.clk_sys(clk_sys), .freq_out(freq_out), .output_enable(output_enable), .overload(overload),
		.ext_run(ext_run), .ext_rev(1'b0), .output_current_pct(output_current_pct),
		.term_run(term_run), .term_rev(term_rev));

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (dc_brake_active === 1'b1) begin
			brake_cnt <= brake_cnt + 1;
		end
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked = checked + 1;
		if (s !== x) begin
			bad_count = bad_count + 1;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	// One APB transfer; entered just after a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wait_st(input logic [2:0] s);
		for (int i = 0; i < 400; i++) begin
			apb(1'b0, `OFS_STATUS, 32'h0);
			if (rdata[2:0] === s) break;
		end
		chk("state", 32'(rdata[2:0]), 32'(s));
	endtask : wait_st

	task automatic wait_oe(input logic v);
		for (int i = 0; i < 400 && output_enable !== v; i++) @(posedge clk_sys);
		chk("output_enable", 32'(output_enable), 32'(v));
	endtask : wait_oe

	task automatic press();
		panel_stop_key <= 1'b1;
		repeat (4) @(posedge clk_sys);
		panel_stop_key <= 1'b0;
	endtask : press

	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, `OFS_CTRL, 32'h0);
		chk("ctrl", rdata, 32'h00000003);
		apb(1'b0, `OFS_FREQ, 32'h0);
		chk("startup_frequency", rdata & 32'h1FF, 32'h5);
		apb(1'b0, `OFS_BRAKE, 32'h0);
		chk("brake", rdata, 32'h00140000);
		apb(1'b0, `OFS_TRACK, 32'h0);
		chk("track", rdata, 32'h00059632);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'(rerr), 32'h1);
		$display("test registers done");
		apb(1'b1, `OFS_SETF, 32'h32);
		apb(1'b1, `OFS_CTRL, 32'h23);
		comm_rev <= 1'b1;
		comm_run <= 1'b1;
		wait_oe(1'b1);
		chk("start_freq", 32'(freq_out), 32'h5);
		chk("no_start_brake", 32'(dc_brake_active), 32'h0);
		wait_st(drive_seq_pkg::ST_RUN);
		chk("run_freq", 32'(freq_out), 32'h32);
		chk("reverse", 32'(reverse_out), 32'h1);
		brake_mark = brake_cnt;
		comm_run <= 1'b0;
		wait_st(drive_seq_pkg::ST_DECEL);
		wait_st(drive_seq_pkg::ST_IDLE);
		chk("coast_brake", 32'(brake_cnt - brake_mark), 32'h0);
		$display("test ramped stop done");
		apb(1'b1, `OFS_BRAKE, 32'h00140300);
		apb(1'b1, `OFS_CTRL, 32'h2A);
		comm_run <= 1'b1;
		wait_st(drive_seq_pkg::ST_RUN);
		chk("reverse_lock", 32'(reverse_out), 32'h0);
		brake_mark = brake_cnt;
		comm_run <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("coast_cut", 32'(output_enable), 32'h0);
		wait_st(drive_seq_pkg::ST_IDLE);
		chk("coast_no_brake", 32'(brake_cnt - brake_mark), 32'h0);
		$display("test coast stop done");
		apb(1'b1, `OFS_BRAKE, 32'h00140302);
		apb(1'b1, `OFS_CTRL, 32'h23);
		comm_run <= 1'b1;
		wait_oe(1'b1);
		chk("start_brake", 32'(dc_brake_active), 32'h1);
		chk("start_brake_volt", 32'(volt_out), 32'h14);
		wait_st(drive_seq_pkg::ST_ACCEL);
		wait_st(drive_seq_pkg::ST_RUN);
		comm_run <= 1'b0;
		wait_st(drive_seq_pkg::ST_STOP_BRAKE);
		chk("stop_brake", 32'(dc_brake_active), 32'h1);
		chk("stop_brake_volt", 32'(volt_out), 32'h14);
		wait_st(drive_seq_pkg::ST_IDLE);
		chk("brake_end", 32'(output_enable), 32'h0);
		$display("test braking done");
		apb(1'b1, `OFS_BRAKE, 32'h00140000);
		comm_run <= 1'b1;
		wait_st(drive_seq_pkg::ST_RUN);
		press();
		wait_st(drive_seq_pkg::ST_IDLE);
		chk("lockout", 32'(rdata[5]), 32'h1);
		repeat (100) @(posedge clk_sys);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk("locked_idle", 32'(rdata[2:0]), 32'(drive_seq_pkg::ST_IDLE));
		comm_run <= 1'b0;
		repeat (5) @(posedge clk_sys);
		comm_run <= 1'b1;
		wait_st(drive_seq_pkg::ST_RUN);
		apb(1'b1, `OFS_CTRL, 32'h21);
		press();
		repeat (40) @(posedge clk_sys);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk("key_disabled", 32'(rdata[2:0]), 32'(drive_seq_pkg::ST_RUN));
		comm_run <= 1'b0;
		wait_st(drive_seq_pkg::ST_IDLE);
		apb(1'b1, `OFS_CTRL, 32'h13);
		ext_run <= 1'b1;
		wait_st(drive_seq_pkg::ST_RUN);
		ext_run <= 1'b0;
		wait_st(drive_seq_pkg::ST_IDLE);
		$display("test stop key done");
		apb(1'b1, `OFS_TRACK, 32'h00059603);
		apb(1'b1, `OFS_CTRL, 32'h25);
		comm_run <= 1'b1;
		wait_oe(1'b1);
		chk("track_freq", 32'(freq_out), 32'h32);
		chk("track_volt", 32'(volt_out), 32'h0);
		overload <= 1'b1;
		wait_st(drive_seq_pkg::ST_ACCEL);
		chk("caught_low", 32'(freq_out < 14'h0032), 32'h1);
		overload <= 1'b0;
		wait_st(drive_seq_pkg::ST_RUN);
		comm_run <= 1'b0;
		wait_st(drive_seq_pkg::ST_IDLE);
		$display("test tracking done");
		stop_test();
	end
endmodule : tb_drive_start_stop_sequencer
